//--- hdl/psmp_pkg.sv
// package: constants, types and helpers for the program stream map parser
// Notes on behaviour
// - A map packet opens with the 24-bit start prefix 0x000001, which with the next byte marks a new packet.
// - The byte after the prefix must be 0xBC for the packet to be taken as a map.
// - A 16-bit map length follows and counts the bytes after it; it never exceeds 1018.
// - A one-bit flag set to one marks the map as in force now, cleared marks it as the next one; current and pending tables are kept apart.
// - The version is that of the map in force when the flag is one and of the next map when it is zero.
// - After the length come the flag, two reserved bits, the version, seven reserved bits and a marker bit that reads one.
// - A 16-bit program information length follows and gives exactly how many descriptor bytes to skip.
// - After those descriptors a 16-bit field gives the byte total of all stream entries, which are looped until used up.
// - Each entry is a stream type byte, a carrying stream identifier byte, a 16-bit descriptor length and that many bytes.
// - Stream type 0x00 is reserved, 0x01 to 0x0E assigned, 0x0F-0x7F reserved and 0x80-0xFF user private.
// - Types 0x01 and 0x02 are video, 0x03 and 0x04 audio, 0x05 private sections, 0x06 private data, 0x07 to 0x0D other assigned.
// - Type 0x0E is an auxiliary stream for system data such as directory or map information.
// - The carrying stream identifier names the identifier byte of the packets that carry the stream and is recorded for routing.
// - The packet ends in a 32-bit check value that leaves the CRC registers at zero; a nonzero result is flagged.
package psmp_pkg;

  // stream syntax
  localparam logic [23:0] START_PREFIX  = 24'h00_0001;
  localparam logic [7:0]  MAP_PACKET_ID = 8'hbc;
  localparam logic [15:0] MAX_MAP_LEN   = 16'h03fa;
  localparam logic [15:0] ESML_BYTES    = 16'h0002;
  localparam logic [15:0] CRC_BYTES     = 16'h0004;
  localparam logic [15:0] ES_HDR_BYTES  = 16'h0004;
  localparam int          CN_POS        = 7;
  localparam int          VER_W         = 5;
  localparam int          MARKER_POS    = 0;

  // crc
  localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

  // table storage
  localparam int TBL_DEPTH = 16;
  localparam int TBL_IDX_W = 4;
  localparam int CNT_W     = 5;
  localparam logic [CNT_W-1:0] TBL_FULL = 5'h10;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_COUNT    = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h14;
  localparam logic [7:0] OFF_ERR      = 8'h18;
  localparam logic [7:0] OFF_TBL_SEL  = 8'h1c;
  localparam logic [7:0] OFF_TBL_DATA = 8'h20;

  // field positions
  localparam int CTRL_EN_POS    = 0;
  localparam int ST_CUR_VALID   = 0;
  localparam int ST_PEND_VALID  = 1;
  localparam int ST_BUSY        = 2;
  localparam int ST_OVF         = 3;
  localparam int ST_CUR_VER_LSB = 8;
  localparam int ST_PND_VER_LSB = 16;
  localparam int CNT_PEND_LSB   = 8;
  localparam int SEL_BANK_POS   = 8;
  localparam int DATA_ID_LSB    = 8;
  localparam int DATA_CLS_LSB   = 16;
  localparam int IRQ_DONE       = 0;
  localparam int IRQ_ERR        = 1;
  localparam int IRQ_VER        = 2;
  localparam int IRQ_W          = 3;
  localparam int ERR_MARKER     = 0;
  localparam int ERR_LEN        = 1;
  localparam int ERR_LOOP       = 2;
  localparam int ERR_CRC        = 3;
  localparam int ERR_W          = 4;

  // reset values and the word transfer size
  localparam logic             CTRL_EN_RST = 1'h1;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST  = 3'h0;
  localparam logic [2:0]       HSIZE_WORD  = 3'h2;

  typedef enum logic [2:0] {
    CLS_RESERVED = 3'b000,
    CLS_VIDEO    = 3'b001,
    CLS_AUDIO    = 3'b010,
    CLS_PRIV_SEC = 3'b011,
    CLS_PRIV_DAT = 3'b100,
    CLS_ASSIGNED = 3'b101,
    CLS_AUX      = 3'b110,
    CLS_USER     = 3'b111
  } psmp_class_e;

  typedef enum logic [3:0] {
    ST_SYNC    = 4'b0000,
    ST_LEN_HI  = 4'b0001,
    ST_LEN_LO  = 4'b0010,
    ST_HDR0    = 4'b0011,
    ST_HDR1    = 4'b0100,
    ST_PIL_HI  = 4'b0101,
    ST_PIL_LO  = 4'b0110,
    ST_PDESC   = 4'b0111,
    ST_ESML_HI = 4'b1000,
    ST_ESML_LO = 4'b1001,
    ST_ES_TYPE = 4'b1010,
    ST_ES_ID   = 4'b1011,
    ST_ESIL_HI = 4'b1100,
    ST_ESIL_LO = 4'b1101,
    ST_ES_DESC = 4'b1110,
    ST_CRC     = 4'b1111
  } psmp_state_e;

  typedef struct packed {
    logic [7:0]  stype;
    logic [7:0]  carrying_stream_identifier;
    psmp_class_e sclass;
  } psmp_entry_s;

  function automatic psmp_class_e psmp_classify(input logic [7:0] t);
    psmp_class_e c;
    c = CLS_RESERVED;
    if (t[7]) c = CLS_USER;
    else if (t == 8'h01 || t == 8'h02) c = CLS_VIDEO;
    else if (t == 8'h03 || t == 8'h04) c = CLS_AUDIO;
    else if (t == 8'h05) c = CLS_PRIV_SEC;
    else if (t == 8'h06) c = CLS_PRIV_DAT;
    else if (t >= 8'h07 && t <= 8'h0d) c = CLS_ASSIGNED;
    else if (t == 8'h0e) c = CLS_AUX;
    return c;
  endfunction : psmp_classify

  function automatic logic [31:0] psmp_crc_step(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[31] ^ b[i]) ? ({r[30:0], 1'b0} ^ CRC_POLY) : {r[30:0], 1'b0};
    end
    return r;
  endfunction : psmp_crc_step

  // crc state once prefix and identifier have gone through
  localparam logic [31:0] CRC_PRESET = psmp_crc_step(psmp_crc_step(psmp_crc_step(
    psmp_crc_step(CRC_INIT, 8'h00), 8'h00), 8'h01), MAP_PACKET_ID);

endpackage : psmp_pkg

//--- hdl/psmp_crc32.sv
// module: byte-wide crc engine for the map check value
`timescale 1ns/10ps
`default_nettype none
module psmp_crc32 (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       load,
  input  wire logic       en,
  input  wire logic [7:0] data,
  output logic            residue_zero
);
  logic [31:0] crc_q;
  logic [31:0] crc_d;

  assign crc_d        = psmp_pkg::psmp_crc_step(crc_q, data);
  // looks ahead so the last byte can be judged in its own cycle
  assign residue_zero = (crc_d == 32'h0000_0000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_q <= psmp_pkg::CRC_INIT;
    end else if (load) begin
      crc_q <= psmp_pkg::CRC_PRESET;
    end else if (en) begin
      crc_q <= crc_d;
    end
  end
endmodule : psmp_crc32
`default_nettype wire

//--- hdl/psmp_top.sv
// module: map packet parser with table store and bus slave
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module psmp_top (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  in_valid,
  input  wire logic [7:0]            in_data,
  output logic                       ent_valid,
  output psmp_pkg::psmp_entry_s      ent,
  output logic                       ent_current,
  output logic                       map_done,
  output logic                       map_error,
  output logic                       irq
);
  localparam int IW = psmp_pkg::IRQ_W;
  localparam int EW = psmp_pkg::ERR_W;
  localparam int CW = psmp_pkg::CNT_W;
  localparam int VW = psmp_pkg::VER_W;
  localparam int DP = psmp_pkg::TBL_DEPTH;

  psmp_pkg::psmp_state_e state_q;
  psmp_pkg::psmp_state_e state_d;
  logic [23:0]           hist_q;
  logic [15:0]           rem_q;
  logic [15:0]           loop_q;
  logic [15:0]           esrem_q;
  logic                  cn_q;
  logic [VW-1:0]         ver_q;
  logic [7:0]            stype_q;
  logic [7:0]            carrier_q;
  logic [15:0]           field16;
  logic [15:0]           rem_left;
  logic [15:0]           es_left;
  logic                  counting;
  logic                  start;
  logic                  residue_zero;
  logic [EW-1:0]         fail;
  logic                  push;
  logic                  finish;
  logic                  commit;
  logic                  ver_ev;
  psmp_pkg::psmp_entry_s entry;

  psmp_pkg::psmp_entry_s work_q [DP];
  psmp_pkg::psmp_entry_s cur_tbl_q [DP];
  psmp_pkg::psmp_entry_s pend_tbl_q [DP];
  logic [CW-1:0]         wcnt_q;
  logic                  wovf_q;
  logic [CW-1:0]         cur_cnt_q;
  logic [CW-1:0]         pend_cnt_q;
  logic [VW-1:0]         cur_ver_q;
  logic [VW-1:0]         pend_ver_q;
  logic                  cur_valid_q;
  logic                  pend_valid_q;
  logic                  ovf_q;

  logic                  ctrl_en_q;
  logic [IW-1:0]         irq_en_q;
  logic [IW-1:0]         irq_stat_q;
  logic [IW-1:0]         irq_stat_d;
  logic [IW-1:0]         irq_clr;
  logic [EW-1:0]         err_q;
  logic [EW-1:0]         err_clr;
  logic [psmp_pkg::TBL_IDX_W-1:0] sel_idx_q;
  logic                  sel_bank_q;
  psmp_pkg::psmp_entry_s tbl_rd;
  logic                  take;
  logic                  wr_q;
  logic [7:0]            waddr_q;
  logic [31:0]           rdata;

  // byte-level decode
  assign field16  = {hist_q[7:0], in_data};
  assign rem_left = rem_q - 16'h0001;
  assign es_left  = esrem_q - 16'h0001;
  assign counting = (state_q != psmp_pkg::ST_SYNC) && (state_q != psmp_pkg::ST_LEN_HI)
                    && (state_q != psmp_pkg::ST_LEN_LO);
  assign start    = in_valid && (state_q == psmp_pkg::ST_SYNC) && ctrl_en_q
                    && (hist_q == psmp_pkg::START_PREFIX)
                    && (in_data == psmp_pkg::MAP_PACKET_ID);
  assign entry    = '{stype: stype_q, carrying_stream_identifier: carrier_q,
                      sclass: psmp_pkg::psmp_classify(stype_q)};
  assign commit   = finish && (fail == '0);
  assign ver_ev   = commit && cn_q && cur_valid_q && (ver_q != cur_ver_q);

  psmp_crc32 u_crc (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .load         (start),
    .en           (in_valid && (state_q != psmp_pkg::ST_SYNC)),
    .data         (in_data),
    .residue_zero (residue_zero)
  );

  always_comb begin
    state_d = state_q;
    fail    = '0;
    push    = 1'b0;
    finish  = 1'b0;
    if (in_valid) begin
      unique case (state_q)
        psmp_pkg::ST_SYNC: begin
          if (start) state_d = psmp_pkg::ST_LEN_HI;
        end
        psmp_pkg::ST_LEN_HI: state_d = psmp_pkg::ST_LEN_LO;
        psmp_pkg::ST_LEN_LO: begin
          state_d = psmp_pkg::ST_HDR0;
          if (field16 > psmp_pkg::MAX_MAP_LEN) fail[psmp_pkg::ERR_LEN] = 1'b1;
        end
        psmp_pkg::ST_HDR0: state_d = psmp_pkg::ST_HDR1;
        psmp_pkg::ST_HDR1: begin
          state_d = psmp_pkg::ST_PIL_HI;
          if (!in_data[psmp_pkg::MARKER_POS]) fail[psmp_pkg::ERR_MARKER] = 1'b1;
        end
        psmp_pkg::ST_PIL_HI: state_d = psmp_pkg::ST_PIL_LO;
        psmp_pkg::ST_PIL_LO: begin
          state_d = (field16 == 16'h0000) ? psmp_pkg::ST_ESML_HI : psmp_pkg::ST_PDESC;
          if (17'(field16) + 17'(psmp_pkg::ESML_BYTES + psmp_pkg::CRC_BYTES) > 17'(rem_left))
            fail[psmp_pkg::ERR_LOOP] = 1'b1;
        end
        psmp_pkg::ST_PDESC: begin
          if (loop_q == 16'h0001) state_d = psmp_pkg::ST_ESML_HI;
        end
        psmp_pkg::ST_ESML_HI: state_d = psmp_pkg::ST_ESML_LO;
        psmp_pkg::ST_ESML_LO: begin
          state_d = (field16 == 16'h0000) ? psmp_pkg::ST_CRC : psmp_pkg::ST_ES_TYPE;
          if (17'(field16) + 17'(psmp_pkg::CRC_BYTES) != 17'(rem_left))
            fail[psmp_pkg::ERR_LOOP] = 1'b1;
        end
        psmp_pkg::ST_ES_TYPE: begin
          state_d = psmp_pkg::ST_ES_ID;
          if (esrem_q < psmp_pkg::ES_HDR_BYTES) fail[psmp_pkg::ERR_LOOP] = 1'b1;
        end
        psmp_pkg::ST_ES_ID: state_d = psmp_pkg::ST_ESIL_HI;
        psmp_pkg::ST_ESIL_HI: state_d = psmp_pkg::ST_ESIL_LO;
        psmp_pkg::ST_ESIL_LO: begin
          push = 1'b1;
          if (field16 > es_left) fail[psmp_pkg::ERR_LOOP] = 1'b1;
          if (field16 != 16'h0000) state_d = psmp_pkg::ST_ES_DESC;
          else if (es_left == 16'h0000) state_d = psmp_pkg::ST_CRC;
          else state_d = psmp_pkg::ST_ES_TYPE;
        end
        psmp_pkg::ST_ES_DESC: begin
          if (loop_q == 16'h0001) begin
            state_d = (es_left == 16'h0000) ? psmp_pkg::ST_CRC : psmp_pkg::ST_ES_TYPE;
          end
        end
        psmp_pkg::ST_CRC: begin
          if (rem_q == 16'h0001) begin
            state_d = psmp_pkg::ST_SYNC;
            finish  = 1'b1;
            if (!residue_zero) fail[psmp_pkg::ERR_CRC] = 1'b1;
          end
        end
      endcase
      // a byte past the stated length means the loops disagreed with it
      if (counting && rem_q == 16'h0000) fail[psmp_pkg::ERR_LOOP] = 1'b1;
      if (fail != '0) begin
        state_d = psmp_pkg::ST_SYNC;
        push    = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= psmp_pkg::ST_SYNC;
      hist_q  <= 24'hff_ffff;
    end else begin
      state_q <= state_d;
      if (in_valid) hist_q <= {hist_q[15:0], in_data};
    end
  end

  // field capture and byte counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem_q     <= 16'h0000;
      loop_q    <= 16'h0000;
      esrem_q   <= 16'h0000;
      cn_q      <= 1'b0;
      ver_q     <= '0;
      stype_q   <= 8'h00;
      carrier_q <= 8'h00;
    end else if (in_valid) begin
      if (counting) rem_q <= rem_left;
      unique case (state_q)
        psmp_pkg::ST_LEN_LO: rem_q <= field16;
        psmp_pkg::ST_HDR0: begin
          cn_q  <= in_data[psmp_pkg::CN_POS];
          ver_q <= in_data[VW-1:0];
        end
        psmp_pkg::ST_PIL_LO: loop_q <= field16;
        psmp_pkg::ST_PDESC: loop_q <= loop_q - 16'h0001;
        psmp_pkg::ST_ESML_LO: esrem_q <= field16;
        psmp_pkg::ST_ES_TYPE: begin
          stype_q <= in_data;
          esrem_q <= es_left;
        end
        psmp_pkg::ST_ES_ID: begin
          carrier_q <= in_data;
          esrem_q   <= es_left;
        end
        psmp_pkg::ST_ESIL_HI: esrem_q <= es_left;
        psmp_pkg::ST_ESIL_LO: begin
          esrem_q <= es_left;
          loop_q  <= field16;
        end
        psmp_pkg::ST_ES_DESC: begin
          esrem_q <= es_left;
          loop_q  <= loop_q - 16'h0001;
        end
        psmp_pkg::ST_SYNC, psmp_pkg::ST_LEN_HI, psmp_pkg::ST_HDR1, psmp_pkg::ST_PIL_HI,
        psmp_pkg::ST_ESML_HI, psmp_pkg::ST_CRC: ;
      endcase
    end
  end

  // working table, discarded unless the packet checks out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      work_q <= '{default: '0};
      wcnt_q <= '0;
      wovf_q <= 1'b0;
    end else if (start) begin
      wcnt_q <= '0;
      wovf_q <= 1'b0;
    end else if (push) begin
      if (wcnt_q < psmp_pkg::TBL_FULL) begin
        work_q[wcnt_q[psmp_pkg::TBL_IDX_W-1:0]] <= entry;
        wcnt_q <= wcnt_q + 5'h01;
      end else begin
        // entries beyond the table depth are dropped and only set the overflow flag
        wovf_q <= 1'b1;
      end
    end
  end

  // current and pending banks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_tbl_q    <= '{default: '0};
      pend_tbl_q   <= '{default: '0};
      cur_cnt_q    <= '0;
      pend_cnt_q   <= '0;
      cur_ver_q    <= '0;
      pend_ver_q   <= '0;
      cur_valid_q  <= 1'b0;
      pend_valid_q <= 1'b0;
      ovf_q        <= 1'b0;
    end else if (commit) begin
      ovf_q <= wovf_q;
      if (cn_q) begin
        cur_tbl_q   <= work_q;
        cur_cnt_q   <= wcnt_q;
        cur_ver_q   <= ver_q;
        cur_valid_q <= 1'b1;
        // the pending map has taken effect once it arrives as current
        if (pend_ver_q == ver_q) pend_valid_q <= 1'b0;
      end else begin
        pend_tbl_q   <= work_q;
        pend_cnt_q   <= wcnt_q;
        pend_ver_q   <= ver_q;
        pend_valid_q <= 1'b1;
      end
    end
  end

  // downstream strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ent_valid   <= 1'b0;
      ent         <= '0;
      ent_current <= 1'b0;
      map_done    <= 1'b0;
      map_error   <= 1'b0;
    end else begin
      ent_valid <= push;
      if (push) begin
        ent         <= entry;
        ent_current <= cn_q;
      end
      map_done  <= commit;
      map_error <= (fail != '0);
    end
  end

  // sticky events; a new event beats a clear in the same cycle
  assign irq_clr    = (wr_q && waddr_q == psmp_pkg::OFF_IRQ_CLR) ? hwdata[IW-1:0] : '0;
  assign err_clr    = (wr_q && waddr_q == psmp_pkg::OFF_ERR) ? hwdata[EW-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | {ver_ev, fail != '0, commit};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
      err_q      <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      err_q      <= (err_q & ~err_clr) | fail;
      irq        <= |(irq_stat_d & irq_en_q);
    end
  end

  // bus slave: zero wait states, reads answered in the data phase
  assign take = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      waddr_q   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_q      <= take && hwrite && (hsize == psmp_pkg::HSIZE_WORD);
      waddr_q   <= haddr;
      hrdata    <= (take && !hwrite) ? rdata : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_q  <= psmp_pkg::CTRL_EN_RST;
      irq_en_q   <= psmp_pkg::IRQ_EN_RST;
      sel_idx_q  <= '0;
      sel_bank_q <= 1'b0;
    end else if (wr_q) begin
      if (waddr_q == psmp_pkg::OFF_CTRL) ctrl_en_q <= hwdata[psmp_pkg::CTRL_EN_POS];
      if (waddr_q == psmp_pkg::OFF_IRQ_EN) irq_en_q <= hwdata[IW-1:0];
      if (waddr_q == psmp_pkg::OFF_TBL_SEL) begin
        sel_idx_q  <= hwdata[psmp_pkg::TBL_IDX_W-1:0];
        sel_bank_q <= hwdata[psmp_pkg::SEL_BANK_POS];
      end
    end
  end

  assign tbl_rd = sel_bank_q ? pend_tbl_q[sel_idx_q] : cur_tbl_q[sel_idx_q];

  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr)
      psmp_pkg::OFF_CTRL: rdata[psmp_pkg::CTRL_EN_POS] = ctrl_en_q;
      psmp_pkg::OFF_STATUS: begin
        rdata[psmp_pkg::ST_CUR_VALID]             = cur_valid_q;
        rdata[psmp_pkg::ST_PEND_VALID]            = pend_valid_q;
        rdata[psmp_pkg::ST_BUSY]                  = (state_q != psmp_pkg::ST_SYNC);
        rdata[psmp_pkg::ST_OVF]                   = ovf_q;
        rdata[psmp_pkg::ST_CUR_VER_LSB +: VW]     = cur_ver_q;
        rdata[psmp_pkg::ST_PND_VER_LSB +: VW]     = pend_ver_q;
      end
      psmp_pkg::OFF_COUNT: begin
        rdata[CW-1:0]                             = cur_cnt_q;
        rdata[psmp_pkg::CNT_PEND_LSB +: CW]       = pend_cnt_q;
      end
      psmp_pkg::OFF_IRQ_STAT: rdata[IW-1:0] = irq_stat_q;
      psmp_pkg::OFF_IRQ_EN: rdata[IW-1:0]   = irq_en_q;
      psmp_pkg::OFF_ERR: rdata[EW-1:0]      = err_q;
      psmp_pkg::OFF_TBL_SEL: begin
        rdata[psmp_pkg::TBL_IDX_W-1:0]            = sel_idx_q;
        rdata[psmp_pkg::SEL_BANK_POS]             = sel_bank_q;
      end
      psmp_pkg::OFF_TBL_DATA: begin
        rdata[7:0]                                = tbl_rd.stype;
        rdata[psmp_pkg::DATA_ID_LSB +: 8]         = tbl_rd.carrying_stream_identifier;
        rdata[psmp_pkg::DATA_CLS_LSB +: 3]        = tbl_rd.sclass;
      end
      default: ;
    endcase
  end

endmodule : psmp_top
`default_nettype wire

//--- dv/psmp_asserts.sv
// checker: port-level assertions for the map parser
`timescale 1ns/10ps
`default_nettype none
module psmp_asserts (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  input wire logic                  in_valid,
  input wire logic                  ent_valid,
  input wire psmp_pkg::psmp_entry_s ent,
  input wire logic                  map_done,
  input wire logic                  map_error
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_done_pulse; map_done ##1 !map_done; endsequence
  sequence s_ent_pulse; ent_valid ##1 !ent_valid; endsequence
  a_done_pulse: assert property (map_done |-> s_done_pulse)
    else $error("map done longer than one cycle");
  a_done_byte: assert property (map_done |-> $past(in_valid))
    else $error("map done without a closing byte");
  a_err_byte: assert property (map_error |-> $past(in_valid) && !map_done)
    else $error("map error without a byte or with done");
  a_ent_pulse: assert property (ent_valid |-> $past(in_valid) ##0 s_ent_pulse)
    else $error("entry pulse malformed");
  a_ent_hold: assert property (!ent_valid |-> $stable(ent))
    else $error("entry changed without a pulse");
  a_user_class: assert property (ent_valid && ent.stype[7] |-> ent.sclass == psmp_pkg::CLS_USER)
    else $error("user private type misclassed");
  a_aux_class: assert property (ent_valid && ent.stype == 8'h0e |-> ent.sclass == psmp_pkg::CLS_AUX)
    else $error("auxiliary type misclassed");
  a_video_class: assert property (ent_valid && ent.stype inside {8'h01, 8'h02}
    |-> ent.sclass == psmp_pkg::CLS_VIDEO)
    else $error("video type misclassed");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rdata_idle: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
endmodule : psmp_asserts
bind psmp_top psmp_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .in_valid(in_valid), .ent_valid(ent_valid), .ent(ent), .map_done(map_done),
  .map_error(map_error));
`default_nettype wire

//--- dv/psmp_src.sv
// partner: upstream byte source that builds map packets
`timescale 1ns/10ps
`default_nettype none
module psmp_src (
  input wire logic  hclk,
  output var logic  in_valid,
  output var logic [7:0] in_data
);
  logic [7:0]  tys [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0d,
                            8'h0e, 8'h0f, 8'h7f, 8'h80, 8'hff};
  logic [31:0] crc;
  logic        cur_cn;
  initial begin
    in_valid = 1'b0;
    in_data  = 8'hff;
  end
  task automatic pb(input logic [7:0] b);
    @(posedge hclk);
    in_valid <= 1'b1;
    in_data  <= b;
    for (int i = 7; i >= 0; i--) crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ b[i]) ? 32'h04c1_1db7 : 0);
  endtask : pb
  // released line toggles so a stale byte is never mistaken for data
  task automatic idle();
    @(posedge hclk);
    in_valid <= 1'b0;
    in_data  <= ~in_data;
  endtask : idle
  task automatic send(input logic cn, input logic [4:0] ver, input int n, input logic mk,
                      input logic bad);
    logic [15:0] len;
    logic [31:0] c;
    cur_cn = cn;
    len = 16'(11 + 4 * n);
    crc = 32'hffff_ffff;
    pb(8'h00); pb(8'h00); pb(8'h01); pb(8'hbc);
    pb(len[15:8]); pb(len[7:0]);
    pb({cn, 2'b11, ver}); pb({7'h7f, mk});
    idle();
    pb(8'h00); pb(8'h01); pb(8'h5a);
    pb(8'h00); pb(8'(4 * n));
    for (int i = 0; i < n; i++) begin
      pb(tys[i]); pb(8'(8'he0 + i)); pb(8'h00); pb(8'h00);
    end
    c = crc ^ {31'h0, bad};
    pb(c[31:24]); pb(c[23:16]); pb(c[15:8]); pb(c[7:0]);
    idle();
  endtask : send
endmodule : psmp_src
`default_nettype wire

//--- dv/testbench.sv
// testbench: map parsing, tables, errors and interrupts
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, in_valid, ent_valid;
  logic ent_current, map_done, map_error, irq;
  logic [7:0] haddr, in_data;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  psmp_pkg::psmp_entry_s ent;
  int fails, samples_checked, ei, nd, ne;
  logic [2:0] cls [14] = '{3'd0, 3'd1, 3'd1, 3'd2, 3'd2, 3'd3, 3'd4, 3'd5, 3'd5, 3'd6,
                           3'd0, 3'd0, 3'd7, 3'd7};
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  psmp_src src (.hclk(hclk), .in_valid(in_valid), .in_data(in_data));
  psmp_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid), .in_data(in_data),
    .ent_valid(ent_valid), .ent(ent), .ent_current(ent_current), .map_done(map_done),
    .map_error(map_error), .irq(irq));
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  always @(posedge hclk) begin
    if (ent_valid === 1'b1) begin
      chk(ent.sclass === cls[ei] && ent.stype === src.tys[ei], "entry class");
      chk(ent.carrying_stream_identifier === 8'(8'he0 + ei), "entry id");
      chk(ent_current === src.cur_cn, "entry flag");
      ei++;
    end
    if (map_done === 1'b1) nd++;
    if (map_error === 1'b1) ne++;
  end
  task automatic give_verdict();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    give_verdict();
  end
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    hsize = psmp_pkg::HSIZE_WORD;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, psmp_pkg::OFF_IRQ_EN, 0); chk(r === 32'h0, "irq enable reset");
    ei = 0; src.send(1, 5'd3, 14, 1, 0); repeat (3) @(posedge hclk);
    chk(nd === 1 && ei === 14, "first map");
    ahb(0, psmp_pkg::OFF_STATUS, 0); chk(r[1:0] === 2'b01 && r[12:8] === 5'd3, "status");
    ahb(0, psmp_pkg::OFF_COUNT, 0); chk(r[4:0] === 5'd14, "count");
    ahb(1, psmp_pkg::OFF_IRQ_EN, 32'h7); repeat (2) @(posedge hclk); chk(irq === 1'b1, "irq on");
    ahb(1, psmp_pkg::OFF_IRQ_CLR, 32'h7); repeat (2) @(posedge hclk); chk(irq === 1'b0, "irq clr");
    ei = 0; src.send(0, 5'd4, 2, 1, 0); repeat (3) @(posedge hclk);
    ahb(0, psmp_pkg::OFF_STATUS, 0); chk(r[1:0] === 2'b11 && r[20:16] === 5'd4, "pending");
    ei = 0; src.send(1, 5'd5, 2, 0, 0); repeat (3) @(posedge hclk);
    ahb(0, psmp_pkg::OFF_ERR, 0); chk(ne === 1 && r[0] === 1'b1, "marker error");
    ei = 0; src.send(1, 5'd5, 2, 1, 1); repeat (3) @(posedge hclk);
    ahb(0, psmp_pkg::OFF_ERR, 0); chk(ne === 2 && r[3] === 1'b1 && irq === 1'b1, "crc");
    ahb(0, psmp_pkg::OFF_STATUS, 0); chk(r[12:8] === 5'd3, "table kept");
    ahb(1, psmp_pkg::OFF_TBL_SEL, 32'h0000_0001); ahb(0, psmp_pkg::OFF_TBL_DATA, 0);
    chk(r === 32'h0001_e101, "table entry");
    ei = 0; src.send(1, 5'd6, 1, 1, 0); repeat (3) @(posedge hclk);
    ahb(0, psmp_pkg::OFF_IRQ_STAT, 0); chk(r[2:0] === 3'b111, "version event");
    ahb(0, 8'h40, 0); chk(r === 32'h0, "unmapped read");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
